// ---- design/sadc_sequencer.sv ----
/*
  Converter control sequencer: control and result registers, conversion
  timing, busy and done flags, completion pulse and standby handling.
  Assumes a plain register port on CLK and an external analog core that
  presents its 10-bit code on RESULT_IN when the timed conversion ends.
*/
`timescale 1ns/100ps
// Summary of operation
// - Mode 00 disabled, 01 single software start, 11 repeat; 10 reserved.
// - Writing start trigger in a conversion mode starts; trigger self-clears.
// - On completion results, done flag and interrupt pulse update together.
// - Repeat mode restarts on same channel after each completion.
// - Writing disabled mode aborts at once; partial result discarded.
// - Busy set at start, cleared at single-mode finish, on abort, and on stop or sleep standby.
// - Reading upper result clears done; read low status first.
// - Result 9..2 in upper register; 1..0 in status bits 7..6.
// - Time code selects 39..1248 clocks; codes 001 and 111 reserved.
// - Control two bits 7..6 and status bits 3..0 read undefined.
// - Standby resets both control registers and blocks their writes.
// - Ladder connects only while converting, or always.
// - Analog input gate: 0 enables inputs, 1 disables them.
// - Four-bit channel select picks the converted input.
// - Control one resets to 0x10; results and status top bits zero.
// - After standby nothing resumes; earlier results are lost.
module sadc_sequencer
  import sadc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Chip power state
  input wire logic STANDBY_STOP_SLOW,
  input wire logic STANDBY_SLEEP,
  // Analog core
  input wire logic [9:0] RESULT_IN,
  output logic CONV_ACTIVE,
  output logic LADDER_ON,
  output logic INPUT_GATE_OFF,
  output logic [3:0] CHANNEL,
  output logic CONVERSION_IRQ
);
  logic rst_meta_ff, rst_sync_ff;
  logic stop_meta_ff, stop_ff, sleep_meta_ff, sleep_ff;
  logic [7:0] ctrl_one_ff, ctrl_two_ff;
  logic [9:0] result_ff;
  logic done_ff, busy_ff;
  logic [10:0] count_ff;
  sadc_state_t state_ff;
  logic standby, wr_one, wr_two, rd_high, start_req, finish, abort;
  logic [1:0] mode;

  // Cycle count for a time code; reserved codes fall back to the shortest
  function automatic logic [10:0] conv_cycles(input logic [2:0] code);
    unique case (code)
      CT_78: conv_cycles = CYC_78;
      CT_156: conv_cycles = CYC_156;
      CT_312: conv_cycles = CYC_312;
      CT_624: conv_cycles = CYC_624;
      CT_1248: conv_cycles = CYC_1248;
      default: conv_cycles = CYC_39;
    endcase
  endfunction : conv_cycles

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Power state pins come from outside the clock domain
  always_ff @(posedge CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      stop_meta_ff <= 1'b0;
      stop_ff <= 1'b0;
      sleep_meta_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end else if (CE) begin
      stop_meta_ff <= STANDBY_STOP_SLOW;
      stop_ff <= stop_meta_ff;
      sleep_meta_ff <= STANDBY_SLEEP;
      sleep_ff <= sleep_meta_ff;
    end
  end

  assign standby = stop_ff | sleep_ff;
  assign mode = ctrl_one_ff[POS_OP_MODE +: 2];
  assign wr_one = WR && (ADDR == OFF_CTRL_ONE) && !standby;
  assign wr_two = WR && (ADDR == OFF_CTRL_TWO) && !standby;
  assign rd_high = RD && (ADDR == OFF_RES_HIGH);
  // Trigger in disabled or reserved mode never starts anything
  assign start_req = (state_ff == ST_IDLE) && ctrl_one_ff[BIT_START_TRIGGER]
                     && (mode == MODE_SINGLE || mode == MODE_REPEAT);
  assign finish = (state_ff == ST_CONV) && (count_ff == 11'h001) && !abort;
  assign abort = standby || (mode == MODE_DISABLED) || (mode == 2'h2);

  always_ff @(posedge CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl_one_ff <= RST_CTRL_ONE;
    end else if (CE) begin
      if (standby) begin
        ctrl_one_ff <= RST_CTRL_ONE;
      end else if (wr_one) begin
        ctrl_one_ff <= WDATA;
      end else if (start_req) begin
        ctrl_one_ff[BIT_START_TRIGGER] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl_two_ff <= RST_CTRL_TWO;
    end else if (CE) begin
      if (standby) begin
        ctrl_two_ff <= RST_CTRL_TWO;
      end else if (wr_two) begin
        ctrl_two_ff <= WDATA;
      end
    end
  end

  // Sequencer and conversion timer
  always_ff @(posedge CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= ST_IDLE;
      count_ff <= 11'h000;
      busy_ff <= 1'b0;
    end else if (CE) begin
      unique case (state_ff)
        ST_IDLE: begin
          if (start_req && !standby) begin
            state_ff <= ST_CONV;
            count_ff <= conv_cycles(ctrl_two_ff[POS_CONV_TIME +: 3]);
            busy_ff <= 1'b1;
          end
        end
        ST_CONV: begin
          if (abort) begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
          end else if (finish && mode == MODE_REPEAT) begin
            count_ff <= conv_cycles(ctrl_two_ff[POS_CONV_TIME +: 3]);
          end else if (finish) begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
          end else begin
            count_ff <= count_ff - 11'h001;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  // Results and done flag; completion wins over a clearing read
  always_ff @(posedge CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      result_ff <= RST_RESULT;
      done_ff <= 1'b0;
      CONVERSION_IRQ <= 1'b0;
    end else if (CE) begin
      CONVERSION_IRQ <= finish;
      if (standby) begin
        result_ff <= RST_RESULT;
        done_ff <= 1'b0;
      end else if (finish) begin
        result_ff <= RESULT_IN;
        done_ff <= 1'b1;
      end else if (rd_high) begin
        done_ff <= 1'b0;
      end
    end
  end

  // Read port; undefined bits read as zero
  always_ff @(posedge CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      RDATA <= 8'h00;
    end else if (CE) begin
      RDATA <= 8'h00;
      if (RD) begin
        unique case (ADDR)
          OFF_CTRL_ONE: RDATA <= ctrl_one_ff;
          OFF_CTRL_TWO: RDATA <= {2'h0, ctrl_two_ff[5:0]};
          OFF_RES_LOW_STATUS: RDATA <= {result_ff[1:0], done_ff, busy_ff, 4'h0};
          OFF_RES_HIGH: RDATA <= result_ff[9:2];
          default: RDATA <= 8'h00;
        endcase
      end
    end
  end

  // Analog core controls
  always_ff @(posedge CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      CONV_ACTIVE <= 1'b0;
      LADDER_ON <= 1'b0;
      INPUT_GATE_OFF <= 1'b1;
      CHANNEL <= 4'h0;
    end else if (CE) begin
      CONV_ACTIVE <= busy_ff;
      // Standby drops the ladder so no reference current flows
      LADDER_ON <= !standby && (busy_ff || ctrl_two_ff[BIT_LADDER_CONNECT]);
      INPUT_GATE_OFF <= ctrl_one_ff[BIT_ANALOG_INPUT_GATE];
      CHANNEL <= ctrl_one_ff[POS_CHANNEL +: 4];
    end
  end

  // Checks
  sequence s_start;
    start_req && !standby && CE;
  endsequence

  // Completion that no abort cancels in the same cycle
  sequence s_finish;
    finish && CE;
  endsequence

  // Read strobe aimed at the low result and status register
  sequence s_status_read;
    RD && CE && (ADDR == OFF_RES_LOW_STATUS);
  endsequence

  // A write to control one in the start cycle loads the trigger from WDATA instead of clearing it
  a_trigger_self_clear: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    (s_start and !wr_one) |=> !ctrl_one_ff[BIT_START_TRIGGER] && busy_ff)
    else $error("trigger not cleared or busy not set");

  a_start_enters: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    s_start |=> state_ff == ST_CONV && busy_ff)
    else $error("start did not enter conversion");

  a_single_ends: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    (s_finish and (mode == MODE_SINGLE)) |=> !busy_ff && state_ff == ST_IDLE)
    else $error("single conversion did not end");

  a_irq_follows_finish: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    CE |=> CONVERSION_IRQ == $past(finish))
    else $error("interrupt pulse not tied to completion");

  // Reload of at least 39 cycles keeps pulses apart in repeat mode
  a_irq_single_pulse: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    CONVERSION_IRQ && CE |=> !CONVERSION_IRQ)
    else $error("interrupt pulse too long");

  a_abort_idle: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    state_ff == ST_CONV && abort && CE |=> state_ff == ST_IDLE)
    else $error("abort did not return to idle");

  a_reserved_mode: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    state_ff == ST_IDLE && mode == 2'h2 |=> !busy_ff)
    else $error("reserved mode started a conversion");

  a_standby_blocks_write: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    standby && CE |=> ctrl_one_ff == RST_CTRL_ONE && ctrl_two_ff == RST_CTRL_TWO)
    else $error("control register changed in standby");

  a_standby_results: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    standby && CE |=> result_ff == RST_RESULT && !done_ff)
    else $error("results kept through standby");

  a_upper_read_data: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    rd_high && CE |=> RDATA == $past(result_ff[9:2]))
    else $error("upper result read wrong");

  a_status_read: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    s_status_read |=> RDATA == {$past(result_ff[1:0]), $past(done_ff), $past(busy_ff), 4'h0})
    else $error("status read wrong");

  a_ctrl_two_read: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    RD && CE && ADDR == OFF_CTRL_TWO |=> RDATA[7:6] == 2'h0)
    else $error("undefined control two bits not zero");

  a_busy_mirror: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    CE |=> CONV_ACTIVE == $past(busy_ff))
    else $error("active output does not follow busy");

  a_channel_copy: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    CE |=> CHANNEL == $past(ctrl_one_ff[POS_CHANNEL +: 4]))
    else $error("channel output does not follow select");

  a_gate_copy: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    CE |=> INPUT_GATE_OFF == $past(ctrl_one_ff[BIT_ANALOG_INPUT_GATE]))
    else $error("input gate output wrong");

  a_ladder_standby: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    standby && CE |=> !LADDER_ON)
    else $error("ladder on in standby");

  a_ladder_busy: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    busy_ff && !standby && CE |=> LADDER_ON)
    else $error("ladder off while converting");

  a_ladder_idle: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    !busy_ff && !ctrl_two_ff[BIT_LADDER_CONNECT] && CE |=> !LADDER_ON)
    else $error("ladder on while idle");

  a_done_with_irq: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    finish && CE |=> done_ff && CONVERSION_IRQ && result_ff == $past(RESULT_IN))
    else $error("completion not reflected together");
  a_repeat_restart: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    finish && CE && mode == MODE_REPEAT && !wr_one |=> busy_ff && state_ff == ST_CONV)
    else $error("repeat did not restart");
  a_abort_no_store: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    state_ff == ST_CONV && mode == MODE_DISABLED && CE |=> !busy_ff && $stable(result_ff))
    else $error("abort stored a result");
  a_busy_standby: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    stop_ff && CE |=> !busy_ff && ctrl_one_ff == RST_CTRL_ONE)
    else $error("standby did not clear");
  a_read_clears_done: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    rd_high && CE && !finish && done_ff |=> !done_ff)
    else $error("upper read kept done");
  a_disabled_no_start: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    state_ff == ST_IDLE && mode == MODE_DISABLED |=> !busy_ff)
    else $error("start in disabled mode");
  a_time_39: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    (s_start and (ctrl_two_ff[POS_CONV_TIME +: 3] == CT_39)) |=> count_ff == CYC_39)
    else $error("wrong conversion time loaded");
  a_timer_counts: assert property (@(posedge CLK) disable iff (!rst_sync_ff)
    state_ff == ST_CONV && CE && !abort && count_ff > 11'h001
      |=> count_ff == $past(count_ff) - 11'h001)
    else $error("timer did not step");
endmodule : sadc_sequencer

// ---- design/sadc_pkg.sv ----
/*
  Package for the converter control sequencer: register offsets, field
  positions, reset values, mode and timing codes.
  Assumes a single 10 MHz clock domain.
*/
package sadc_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] OFF_CTRL_ONE = 8'h1c;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h1d;
  localparam logic [7:0] OFF_RES_LOW_STATUS = 8'h1e;
  localparam logic [7:0] OFF_RES_HIGH = 8'h1f;

  // Control one fields
  localparam int BIT_START_TRIGGER = 7;
  localparam int POS_OP_MODE = 5;
  localparam int BIT_ANALOG_INPUT_GATE = 4;
  localparam int POS_CHANNEL = 0;
  localparam logic [7:0] RST_CTRL_ONE = 8'h10;

  // Control two fields
  localparam int BIT_LADDER_CONNECT = 5;
  localparam int BIT_CTRL_TWO_ONE = 4;
  localparam int POS_CONV_TIME = 1;
  localparam logic [7:0] RST_CTRL_TWO = 8'h10;

  // Status fields
  localparam int BIT_DONE = 5;
  localparam int BIT_BUSY = 4;
  localparam logic [9:0] RST_RESULT = 10'h000;

  // Operating modes
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_REPEAT = 2'h3;

  // Conversion time codes and cycle counts of the high-frequency clock
  localparam logic [2:0] CT_39 = 3'h0;
  localparam logic [2:0] CT_78 = 3'h2;
  localparam logic [2:0] CT_156 = 3'h3;
  localparam logic [2:0] CT_312 = 3'h4;
  localparam logic [2:0] CT_624 = 3'h5;
  localparam logic [2:0] CT_1248 = 3'h6;
  localparam logic [10:0] CYC_39 = 11'h027;
  localparam logic [10:0] CYC_78 = 11'h04e;
  localparam logic [10:0] CYC_156 = 11'h09c;
  localparam logic [10:0] CYC_312 = 11'h138;
  localparam logic [10:0] CYC_624 = 11'h270;
  localparam logic [10:0] CYC_1248 = 11'h4e0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } sadc_state_t;
endpackage : sadc_pkg

// ---- sim/tb_sadc_sequencer.sv ----
/*
  Self-checking bench for the converter control sequencer: registers,
  timing codes, single and repeat runs, abort, standby handling.
  Assumes sadc_pkg and sadc_sequencer are compiled first; CE drops only in t_freeze.
*/
`timescale 1ns/100ps
module tb_sadc_sequencer;
  import sadc_pkg::*;
  logic CLK = 1'b0, ARST_N = 1'b0, CE = 1'b1, WR = 1'b0, RD = 1'b0;
  logic STANDBY_STOP_SLOW = 1'b0, STANDBY_SLEEP = 1'b0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
  logic [9:0] RESULT_IN = 10'h2d5;
  logic [3:0] CHANNEL;
  logic CONV_ACTIVE, LADDER_ON, INPUT_GATE_OFF, CONVERSION_IRQ;
  int fail_count = 0, compares = 0, cycles = 0;
  always #50 CLK = ~CLK;
  sadc_sequencer i_sadc_sequencer (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .STANDBY_STOP_SLOW(STANDBY_STOP_SLOW),
    .STANDBY_SLEEP(STANDBY_SLEEP), .RESULT_IN(RESULT_IN), .CONV_ACTIVE(CONV_ACTIVE),
    .LADDER_ON(LADDER_ON), .INPUT_GATE_OFF(INPUT_GATE_OFF), .CHANNEL(CHANNEL),
    .CONVERSION_IRQ(CONVERSION_IRQ));
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // Hang guard: the longest run needs well under this
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    check(RDATA, exp);
  endtask : rd_chk
  task automatic idle(input int n);
    repeat (n) @(negedge CLK);
  endtask : idle
  task automatic t_reset;
    rd_chk(OFF_CTRL_ONE, RST_CTRL_ONE);
    rd_chk(OFF_CTRL_TWO, RST_CTRL_TWO);
    rd_chk(OFF_RES_LOW_STATUS, 8'h00);
    rd_chk(OFF_RES_HIGH, 8'h00);
    rd_chk(8'h20, 8'h00);
    check(INPUT_GATE_OFF, 1'b1);
  endtask : t_reset
  // Single start on channel 4; busy copy must stand exactly n cycles
  task automatic conv(input logic [2:0] code, input int n);
    int len;
    int irq_n;
    len = 0;
    irq_n = 0;
    wr(OFF_CTRL_TWO, 8'h10 | {4'h0, code, 1'b0});
    wr(OFF_CTRL_ONE, 8'ha4);
    for (int i = 0; i < 8 && CONV_ACTIVE !== 1'b1; i++) @(negedge CLK);
    check(LADDER_ON, 1'b1);
    while (CONV_ACTIVE === 1'b1 && len < 1300) begin
      len++;
      irq_n += (CONVERSION_IRQ === 1'b1);
      @(negedge CLK);
    end
    repeat (4) begin
      irq_n += (CONVERSION_IRQ === 1'b1);
      @(negedge CLK);
    end
    check(len, n);
    check(irq_n, 1);
    check(LADDER_ON, 1'b0);
  endtask : conv
  task automatic t_times;
    logic [2:0] codes [7] = '{CT_78, CT_156, CT_312, CT_624, CT_1248, 3'h1, 3'h7};
    logic [10:0] lens [7] = '{CYC_78, CYC_156, CYC_312, CYC_624, CYC_1248, CYC_39, CYC_39};
    for (int i = 0; i < 7; i++) conv(codes[i], int'(lens[i]));
  endtask : t_times
  task automatic t_single;
    conv(CT_39, int'(CYC_39));
    check(CHANNEL, 4'h4);
    check(INPUT_GATE_OFF, 1'b0);
    rd_chk(OFF_RES_LOW_STATUS, {RESULT_IN[1:0], 6'h20});
    rd_chk(OFF_RES_HIGH, RESULT_IN[9:2]);
    rd_chk(OFF_RES_LOW_STATUS, {RESULT_IN[1:0], 6'h00});
  endtask : t_single
  task automatic t_repeat;
    wr(OFF_CTRL_ONE, 8'he5);
    rd_chk(OFF_CTRL_ONE, 8'h65);
    rd_chk(OFF_RES_LOW_STATUS, 8'h50);
    for (int i = 0; i < 60 && CONVERSION_IRQ !== 1'b1; i++) @(negedge CLK);
    check(CONVERSION_IRQ, 1'b1);
    idle(int'(CYC_39));
    check(CONVERSION_IRQ, 1'b1);
    check(CHANNEL, 4'h5);
    @(posedge CLK);
    RESULT_IN <= 10'h1a6;
    idle(12);
    wr(OFF_CTRL_ONE, 8'h05);
    idle(3);
    check(CONV_ACTIVE, 1'b0);
    for (int i = 0; i < 60; i++) begin
      if (CONVERSION_IRQ !== 1'b0) check(CONVERSION_IRQ, 1'b0);
      @(negedge CLK);
    end
    rd_chk(OFF_RES_HIGH, 8'hb5);
    // Trigger with disabled mode, then with the reserved mode
    wr(OFF_CTRL_ONE, 8'h85);
    idle(3);
    check(CONV_ACTIVE, 1'b0);
    wr(OFF_CTRL_ONE, 8'hc5);
    idle(3);
    check(CONV_ACTIVE, 1'b0);
    rd_chk(OFF_RES_LOW_STATUS, 8'h40);
  endtask : t_repeat
  task automatic t_standby;
    wr(OFF_CTRL_TWO, 8'h3c);
    wr(OFF_CTRL_ONE, 8'ha4);
    idle(20);
    check(LADDER_ON, 1'b1);
    @(posedge CLK);
    STANDBY_STOP_SLOW <= 1'b1;
    idle(5);
    check(CONV_ACTIVE, 1'b0);
    check(LADDER_ON, 1'b0);
    wr(OFF_CTRL_ONE, 8'ha3);
    rd_chk(OFF_CTRL_ONE, RST_CTRL_ONE);
    rd_chk(OFF_CTRL_TWO, RST_CTRL_TWO);
    rd_chk(OFF_RES_HIGH, 8'h00);
    rd_chk(OFF_RES_LOW_STATUS, 8'h00);
    @(posedge CLK);
    STANDBY_STOP_SLOW <= 1'b0;
    idle(50);
    check(CONV_ACTIVE, 1'b0);
    @(posedge CLK);
    STANDBY_SLEEP <= 1'b1;
    idle(5);
    wr(OFF_CTRL_ONE, 8'h45);
    @(posedge CLK);
    STANDBY_SLEEP <= 1'b0;
    idle(5);
    rd_chk(OFF_CTRL_ONE, RST_CTRL_ONE);
  endtask : t_standby
  // Clock enable low in mid-conversion must stretch it, not end it
  task automatic t_freeze;
    wr(OFF_CTRL_ONE, 8'ha4);
    idle(10);
    @(posedge CLK);
    CE <= 1'b0;
    idle(50);
    check(CONV_ACTIVE, 1'b1);
    check(CONVERSION_IRQ, 1'b0);
    @(posedge CLK);
    CE <= 1'b1;
    idle(40);
    check(CONV_ACTIVE, 1'b0);
    rd_chk(OFF_RES_LOW_STATUS, 8'ha0);
    rd_chk(OFF_RES_HIGH, 8'h69);
  endtask : t_freeze
  initial begin
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    t_reset();
    t_times();
    t_single();
    t_repeat();
    t_standby();
    t_freeze();
    summarize();
  end
endmodule : tb_sadc_sequencer
